// >>> rtir_dev.sv
// interrupt processor end: record, recognise, restore, force, clear
// Functional notes
// - restore re-enables named line and lower lines
// - restore returns stored words for low lines
// - core puts line number in low six bits
// - no jump after restore: disable except parity
// - restore-and-interrupt raises core restore interrupt
// - restore interrupt needs core interrupts enabled
// - core real-time flag set and cleared
// - low lines save condition register automatically
// - after a low-line interrupt, higher priority recognisable from first fetch
// - high-line routine copies back, then restores
// - address: base, line bits 2-7, zeros
// - high-line interrupt locks until condition copy
// - device generates word parity on store, core checks it on restore
// - each group keeps group and third-word parity
// - parity error only after restore, abnormal
// - force sets real lines, handled as external
// - program clear resets enable, disable, records
// - disabling returns recognised line to recorded
// - in-service line blocked until its restore
// - four file words per low line, 4*line
`timescale 1ns/1ps
`include "rtir_cfg.svh"
module rtir_dev
   import rtir_pkg::*;
#(
   parameter int LINES = `RTIR_LINES
) (
   // clock, reset, enable
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic             i_ce,
   // external interrupt lines and mask
   input  wire logic [LINES-1:0] i_irq,
   input  wire logic [LINES-1:0] i_mask,
   // abnormal interrupt in the core
   input  wire logic             i_abnormal,
   // status
   output logic                  o_enabled,
   output logic [LINES-1:0]      o_recorded,
   // link
   rtir_if.dev                   lnk
);
   localparam int FW = `RTIR_FILE_W;
   localparam int GW = `RTIR_GROUP_WORDS;

   logic [LINES-1:0] irq_s1_q, irq_s2_q;
   logic [LINES-1:0] rec_q, svc_q;
   logic             en_q, auto_dis_q, lock_q, hold_q;
   logic             rt_int_q;
   rtir_line_t       cur_q, rs_line_q;
   logic [`RTIR_BASE_W-1:0] base_q;
   logic [`RTIR_ADDR_W-1:0] addr_q;
   rtir_word_t       file_q [0:(`RTIR_LOW_LINES*GW)-1];
   rtir_xfer_t       st_q;
   logic [1:0]       cnt_q;
   logic             rs_vld_q;
   rtir_word_t       rs_word_q;
   logic [`RTIR_DATA_W-1:0] acc_q;

   logic cmd_rst, cmd_clr, cmd_dis, disable_ev;
   logic [LINES-1:0] reenable;
   logic             any_pick;
   rtir_line_t       pick_line;

   assign cmd_rst = lnk.cmd_vld && (lnk.cmd == `RTIR_CMD_RESTORE ||
                                   lnk.cmd == `RTIR_CMD_RST_INT);
   assign cmd_clr = lnk.cmd_vld && lnk.cmd == `RTIR_CMD_CLEAR;
   assign cmd_dis = lnk.cmd_vld && lnk.cmd == `RTIR_CMD_DISABLE;
   assign disable_ev = cmd_dis || i_abnormal;

   // named line and every lower priority (higher number) line
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         reenable[i] = (i >= int'(lnk.cmd_line));
      end
   end

   // lowest numbered recorded line wins
   always_comb begin
      any_pick = 1'b0;
      pick_line = '0;
      for (int i = LINES-1; i >= 0; i--) begin
         if (rec_q[i] && !svc_q[i]) begin
            any_pick = 1'b1;
            pick_line = rtir_line_t'(i);
         end
      end
   end

   // --------------------------------------------------------------
   // line sampling
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         irq_s1_q <= '0;
         irq_s2_q <= '0;
      end else if (i_ce) begin
         irq_s1_q <= i_irq;
         irq_s2_q <= irq_s1_q;
      end
   end

   // --------------------------------------------------------------
   // recording: force and sampled lines, blocked while in service
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         rec_q <= '0;
      end else if (i_ce) begin
         for (int i = 0; i < LINES; i++) begin
            if (!svc_q[i]) begin
               if ((irq_s2_q[i] && i_mask[i]) ||
                   (lnk.cmd_vld && lnk.cmd == `RTIR_CMD_FORCE &&
                    lnk.force_mask[i])) begin
                  rec_q[i] <= 1'b1;
               end
            end
         end
         if (rt_int_q && lnk.int_ack) begin
            rec_q[cur_q] <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // service state: lines taken and held until restored
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         svc_q <= '0;
      end else if (i_ce) begin
         if (cmd_rst) begin
            svc_q <= svc_q & ~reenable;
         end
         if (rt_int_q && lnk.int_ack) begin
            svc_q[cur_q] <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // enable, automatic disable and recognition locks
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         en_q <= 1'b0;
         auto_dis_q <= 1'b0;
      end else if (i_ce) begin
         if (i_abnormal) begin
            auto_dis_q <= en_q;
            en_q <= 1'b0;
         end else if (cmd_dis) begin
            en_q <= 1'b0;
         end else if (lnk.cmd_vld && lnk.cmd == `RTIR_CMD_ENABLE) begin
            // enable after abnormal sets enable and clears the automatic disable
            en_q <= 1'b1;
            auto_dis_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         lock_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (i_ce) begin
         if (rt_int_q && lnk.int_ack) begin
            // low lines wait for the first fetch, high for the copy
            lock_q <= 1'b1;
            hold_q <= (cur_q >= rtir_line_t'(`RTIR_LOW_LINES));
         end else if (lock_q && !hold_q && lnk.fetch &&
                      st_q == RTIR_ST_IDLE) begin
            lock_q <= 1'b0;
         end else if (lock_q && hold_q && lnk.cra_done) begin
            lock_q <= 1'b0;
            hold_q <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // recognition and interrupt address
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         rt_int_q <= 1'b0;
         cur_q <= '0;
         addr_q <= '0;
         base_q <= '0;
      end else if (i_ce) begin
         if (lnk.cmd_vld && lnk.cmd == `RTIR_CMD_BASE) begin
            base_q <= lnk.base_addr;
         end
         if (disable_ev) begin
            rt_int_q <= 1'b0;
         end else if (rt_int_q && lnk.int_ack) begin
            rt_int_q <= 1'b0;
         end else if (!rt_int_q && en_q && !lock_q && any_pick) begin
            rt_int_q <= 1'b1;
            cur_q <= pick_line;
            addr_q <= {base_q, pick_line, 2'b00};
         end
      end
   end

   // --------------------------------------------------------------
   // register file transfers for the low lines
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || (i_ce && cmd_clr)) begin
         st_q <= RTIR_ST_IDLE;
         cnt_q <= '0;
         rs_vld_q <= 1'b0;
         rs_word_q <= '0;
         rs_line_q <= '0;
         acc_q <= '0;
      end else if (i_ce) begin
         rs_vld_q <= 1'b0;
         case (st_q)
            RTIR_ST_IDLE: begin
               cnt_q <= '0;
               acc_q <= '0;
               if (rt_int_q && lnk.int_ack &&
                   cur_q < rtir_line_t'(`RTIR_LOW_LINES)) begin
                  st_q <= RTIR_ST_STORE;
                  rs_line_q <= cur_q;
               end else if (cmd_rst &&
                   lnk.cmd_line < rtir_line_t'(`RTIR_LOW_LINES)) begin
                  st_q <= RTIR_ST_RESTORE;
                  rs_line_q <= lnk.cmd_line;
               end
            end
            RTIR_ST_STORE: begin
               if (lnk.st_vld) begin
                  file_q[{rs_line_q[3:0], cnt_q}] <= lnk.st_word;
                  acc_q <= acc_q ^ lnk.st_word[`RTIR_DATA_W-1:0];
                  if (cnt_q == 2'(GW-1)) begin
                     // group parity over all four data words
                     file_q[{rs_line_q[3:0], cnt_q}] <= {
                        ^(acc_q ^ lnk.st_word[`RTIR_DATA_W-1:0]),
                        lnk.st_word[`RTIR_PAR_ALL_BIT-1:0]};
                     st_q <= RTIR_ST_IDLE;
                  end else if (cnt_q == 2'h2) begin
                     file_q[{rs_line_q[3:0], cnt_q}] <= {
                        ^lnk.st_word[`RTIR_DATA_W-1:0],
                        lnk.st_word[`RTIR_PAR_W3_BIT-1:0]};
                  end
                  cnt_q <= cnt_q + 2'h1;
               end
            end
            RTIR_ST_RESTORE: begin
               rs_vld_q <= 1'b1;
               rs_word_q <= file_q[{rs_line_q[3:0], cnt_q}];
               cnt_q <= cnt_q + 2'h1;
               if (cnt_q == 2'(GW-1)) begin
                  st_q <= RTIR_ST_IDLE;
               end
            end
            default: st_q <= RTIR_ST_IDLE;
         endcase
      end
   end

   assign lnk.rt_int   = rt_int_q;
   assign lnk.int_addr = addr_q;
   assign lnk.rs_vld   = rs_vld_q;
   assign lnk.rs_word  = rs_word_q;
   assign o_enabled    = en_q;
   assign o_recorded   = rec_q;
endmodule

// >>> rtir_cfg.svh
// constants for the real-time interrupt restore logic
`ifndef RTIR_CFG_SVH
`define RTIR_CFG_SVH
`define RTIR_LINES        64
`define RTIR_LINE_W       6
`define RTIR_LOW_LINES    16
`define RTIR_BASE_W       7
`define RTIR_ADDR_W       15
`define RTIR_WORD_W       28
`define RTIR_DATA_W       24
`define RTIR_FILE_W       6
`define RTIR_GROUP_WORDS  4
`define RTIR_PAR_ALL_BIT  27
`define RTIR_PAR_W3_BIT   27
`define RTIR_LOW_GROUP_B  4
`define RTIR_CMD_W        3
`define RTIR_CMD_NONE     3'h0
`define RTIR_CMD_RESTORE  3'h1
`define RTIR_CMD_RST_INT  3'h2
`define RTIR_CMD_FORCE    3'h3
`define RTIR_CMD_CLEAR    3'h4
`define RTIR_CMD_ENABLE   3'h5
`define RTIR_CMD_DISABLE  3'h6
`define RTIR_CMD_BASE     3'h7
`endif

// >>> rtir_pkg.sv
// shared types for the real-time interrupt restore logic
`include "rtir_cfg.svh"
package rtir_pkg;
   typedef logic [`RTIR_LINE_W-1:0]  rtir_line_t;
   typedef logic [`RTIR_WORD_W-1:0]  rtir_word_t;
   typedef logic [`RTIR_CMD_W-1:0]   rtir_cmd_t;
   typedef enum logic [1:0] {
      RTIR_ST_IDLE,
      RTIR_ST_STORE,
      RTIR_ST_RESTORE
   } rtir_xfer_t;
endpackage

// >>> rtir_if.sv
// link between the interrupt processor and the processor core
`timescale 1ns/1ps
`include "rtir_cfg.svh"
interface rtir_if;
   import rtir_pkg::*;
   // command from the core
   logic                    cmd_vld;
   rtir_cmd_t               cmd;
   logic [`RTIR_LINE_W-1:0] cmd_line;
   logic [`RTIR_LINES-1:0]  force_mask;
   logic [`RTIR_BASE_W-1:0] base_addr;
   // register words, core to device
   logic                    st_vld;
   rtir_word_t              st_word;
   // register words, device to core
   logic                    rs_vld;
   rtir_word_t              rs_word;
   // interrupt request to the core; acknowledge, copy done and fetch back from it
   logic                    rt_int;
   logic [`RTIR_ADDR_W-1:0] int_addr;
   logic                    int_ack;
   logic                    cra_done;
   logic                    fetch;
   modport dev (
      input  cmd_vld, cmd, cmd_line, force_mask, base_addr,
      input  st_vld, st_word, int_ack, cra_done, fetch,
      output rs_vld, rs_word, rt_int, int_addr
   );
   modport cpu (
      output cmd_vld, cmd, cmd_line, force_mask, base_addr,
      output st_vld, st_word, int_ack, cra_done, fetch,
      input  rs_vld, rs_word, rt_int, int_addr
   );
endinterface

// >>> rtir_cpu.sv
// processor core end: commands, flag, restore interrupt, parity check
`timescale 1ns/1ps
`include "rtir_cfg.svh"
module rtir_cpu
   import rtir_pkg::*;
(
   // clock, reset, enable
   input  wire logic                    i_clk,
   input  wire logic                    i_srst,
   input  wire logic                    i_ce,
   // instruction requests from the core sequencer
   input  wire logic                    i_cmd_vld,
   input  wire rtir_cmd_t               i_cmd,
   input  wire logic [`RTIR_LINE_W-1:0] i_cmd_line,
   input  wire logic [`RTIR_LINES-1:0]  i_force_mask,
   input  wire logic [`RTIR_BASE_W-1:0] i_base_addr,
   input  wire logic                    i_jump,
   input  wire logic                    i_fetch,
   input  wire logic                    i_cra,
   input  wire logic                    i_int_sys_en,
   input  wire logic                    i_normal_ack,
   // register words to store
   input  wire logic                    i_st_vld,
   input  wire logic [`RTIR_DATA_W-1:0] i_st_data,
   // status
   output logic                         o_rt_flag,
   output logic                         o_restore_int,
   output logic                         o_rt_disabled,
   output logic                         o_parity_err,
   output logic                         o_take,
   output logic [`RTIR_ADDR_W-1:0]      o_int_addr,
   output logic                         o_rs_vld,
   output logic [`RTIR_DATA_W-1:0]      o_rs_data,
   // link
   rtir_if.cpu                          lnk
);
   logic rt_flag_q, rst_int_q, rt_dis_q, after_rst_q, perr_q, pend_q;
   logic take_q, rs_vld_q;
   logic [`RTIR_ADDR_W-1:0] addr_q;
   logic [`RTIR_DATA_W-1:0] rs_data_q;
   logic [1:0] rcnt_q;
   logic       acc_q;
   logic       take;
   logic       w3p, allp;

   // real-time interrupt needs no mask and no enabled interrupt system
   assign take = lnk.rt_int && !rt_dis_q && !take_q;
   assign w3p  = ^lnk.rs_word[`RTIR_DATA_W-1:0];
   assign allp = acc_q ^ w3p;

   // --------------------------------------------------------------
   // real-time flag and restore interrupt
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rt_flag_q <= 1'b0;
         rst_int_q <= 1'b0;
      end else if (i_ce) begin
         if (take) begin
            rt_flag_q <= 1'b1;
         end else if (i_normal_ack) begin
            rt_flag_q <= 1'b0;
         end
         if (i_cmd_vld && i_cmd == `RTIR_CMD_RST_INT && rt_flag_q) begin
            rst_int_q <= 1'b1;
         end else if (i_normal_ack) begin
            rst_int_q <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // post-restore disable and parity check
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rt_dis_q <= 1'b0;
         after_rst_q <= 1'b0;
         perr_q <= 1'b0;
         pend_q <= 1'b0;
         rcnt_q <= '0;
         acc_q <= 1'b0;
      end else if (i_ce) begin
         perr_q <= 1'b0;
         if (i_cmd_vld && (i_cmd == `RTIR_CMD_RESTORE ||
                           i_cmd == `RTIR_CMD_RST_INT)) begin
            after_rst_q <= 1'b1;
            // a late error from an earlier restore must not linger
            pend_q <= 1'b0;
            rcnt_q <= '0;
            acc_q <= 1'b0;
         end else if (i_fetch && after_rst_q) begin
            after_rst_q <= 1'b0;
            rt_dis_q <= !i_jump;
            perr_q <= pend_q;
            pend_q <= 1'b0;
         end else if (i_jump) begin
            rt_dis_q <= 1'b0;
         end
         if (lnk.rs_vld) begin
            rcnt_q <= rcnt_q + 2'h1;
            acc_q <= acc_q ^ w3p;
            if (rcnt_q == 2'h2 && w3p != lnk.rs_word[`RTIR_PAR_W3_BIT]) begin
               pend_q <= 1'b1;
            end
            if (rcnt_q == 2'h3 && allp != lnk.rs_word[`RTIR_PAR_ALL_BIT]) begin
               pend_q <= 1'b1;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // taking the interrupt and link outputs
   // --------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         take_q <= 1'b0;
         addr_q <= '0;
         rs_vld_q <= 1'b0;
         rs_data_q <= '0;
      end else if (i_ce) begin
         take_q <= take;
         if (take) begin
            addr_q <= lnk.int_addr;
         end
         rs_vld_q <= lnk.rs_vld;
         if (lnk.rs_vld) begin
            rs_data_q <= lnk.rs_word[`RTIR_DATA_W-1:0];
         end
      end
   end

   assign lnk.cmd_vld    = i_cmd_vld;
   assign lnk.cmd        = i_cmd;
   assign lnk.cmd_line   = i_cmd_line;
   assign lnk.force_mask = i_force_mask;
   assign lnk.base_addr  = i_base_addr;
   assign lnk.int_ack    = take;
   assign lnk.cra_done   = i_cra;
   assign lnk.fetch      = i_fetch;
   assign lnk.st_vld     = i_st_vld;
   assign lnk.st_word    = {4'h0, i_st_data};
   assign o_rt_flag      = rt_flag_q;
   assign o_restore_int  = rst_int_q && i_int_sys_en;
   assign o_rt_disabled  = rt_dis_q;
   assign o_parity_err   = perr_q;
   assign o_take         = take_q;
   assign o_int_addr     = addr_q;
   assign o_rs_vld       = rs_vld_q;
   assign o_rs_data      = rs_data_q;
endmodule

// >>> rtir_checker.sv
// assertions on the link between the two ends
`timescale 1ns/1ps
`include "rtir_cfg.svh"
module rtir_checker
   import rtir_pkg::*;
(
   // clock and reset
   input wire logic                    i_clk,
   input wire logic                    i_srst,
   // link signals
   input wire logic                    cmd_vld,
   input wire rtir_cmd_t               cmd,
   input wire logic [`RTIR_LINE_W-1:0] cmd_line,
   input wire logic [`RTIR_BASE_W-1:0] base_addr,
   input wire logic                    fetch,
   input wire logic                    cra_done,
   input wire logic                    int_ack,
   input wire logic                    rs_vld,
   input wire logic                    rt_int,
   input wire logic [`RTIR_ADDR_W-1:0] int_addr
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   logic [`RTIR_BASE_W-1:0] base_q;
   logic                    lock_q;
   logic                    hi_q;
   logic                    rst_cmd;
   assign rst_cmd = cmd_vld && (cmd == `RTIR_CMD_RESTORE ||
                                cmd == `RTIR_CMD_RST_INT);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         base_q <= '0;
      end else if (cmd_vld && cmd == `RTIR_CMD_BASE) begin
         base_q <= base_addr;
      end
   end
   // lock ends on cra for high lines, on first fetch for low ones
   always_ff @(posedge i_clk) begin
      if (i_srst || (cmd_vld && cmd == `RTIR_CMD_CLEAR)) begin
         lock_q <= 1'h0;
         hi_q   <= 1'h0;
      end else if (rt_int && int_ack) begin
         lock_q <= 1'h1;
         hi_q   <= |int_addr[7:6];
      end else if (hi_q ? cra_done : fetch) begin
         lock_q <= 1'h0;
      end
   end
   sequence low_rst_s;
      rst_cmd && cmd_line < 6'h10;
   endsequence
   sequence four_words_s;
      rs_vld [*4] ##1 !rs_vld;
   endsequence
   sequence quiet_s;
      !rt_int ##1 !rt_int;
   endsequence
   addr_base_a:
   assert property (rt_int |-> int_addr[14:8] == base_q)
      else $error("interrupt address lacks the stored base");
   addr_zero_a:
   assert property (rt_int |-> int_addr[1:0] == 2'h0)
      else $error("interrupt address low bits not zero");
   // the file read takes one cycle before the first word leaves
   restore_words_a:
   assert property (low_rst_s |=> ##1 four_words_s)
      else $error("low line restore did not return four words");
   high_no_words_a:
   assert property (rst_cmd && cmd_line >= 6'h10 && !rs_vld |=> !rs_vld)
      else $error("high line restore returned words");
   entry_lock_a:
   assert property (lock_q |-> !rt_int)
      else $error("interrupt raised while entry lock held");
   ack_drop_a:
   assert property (rt_int && int_ack |=> !rt_int)
      else $error("interrupt request stood after acknowledge");
   disable_drop_a:
   assert property (cmd_vld && cmd == `RTIR_CMD_DISABLE |=> quiet_s)
      else $error("interrupt raised after disable");
   clear_drop_a:
   assert property (cmd_vld && cmd == `RTIR_CMD_CLEAR |=> quiet_s)
      else $error("interrupt raised after program clear");
endmodule

// >>> tb_rt_interrupt_restore_logic.sv
// self-checking bench joining both ends of the restore link
`timescale 1ns/1ps
`include "rtir_cfg.svh"
module tb_rt_interrupt_restore_logic
   import rtir_pkg::*;
;
   logic        i_clk = 1'h0;
   logic        i_srst = 1'h1;
   logic [63:0] irq, fm, rec;
   logic [6:0]  base;
   logic [5:0]  cline, h, g, l;
   logic [3:0]  pl;
   logic [23:0] sdata, rs_data;
   logic [14:0] iaddr, tk_addr;
   logic        cvld, se, sv, en, rt_flag, rst_int, rt_dis, perr, take;
   logic        rs_vld;
   rtir_cmd_t   cmd;
   logic [23:0] d [4];
   int          bad_count, n_tests, tk_cnt, tk_done, pe_cnt;
   rtir_if lnk ();
   rtir_dev rtir_dev_inst (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'h1),
      .i_irq(irq), .i_mask({64{1'h1}}), .i_abnormal(1'h0),
      .o_enabled(en), .o_recorded(rec), .lnk(lnk));
   rtir_cpu rtir_cpu_inst (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'h1),
      .i_cmd_vld(cvld), .i_cmd(cmd), .i_cmd_line(cline),
      .i_force_mask(fm), .i_base_addr(base), .i_jump(pl[0]),
      .i_fetch(pl[1]), .i_cra(pl[2]), .i_int_sys_en(se),
      .i_normal_ack(pl[3]), .i_st_vld(sv), .i_st_data(sdata),
      .o_rt_flag(rt_flag), .o_restore_int(rst_int), .o_rt_disabled(rt_dis),
      .o_parity_err(perr), .o_take(take), .o_int_addr(iaddr),
      .o_rs_vld(rs_vld), .o_rs_data(rs_data), .lnk(lnk));
   rtir_checker rtir_checker_inst (.i_clk(i_clk), .i_srst(i_srst),
      .cmd_vld(lnk.cmd_vld), .cmd(lnk.cmd), .cmd_line(lnk.cmd_line),
      .base_addr(lnk.base_addr), .fetch(lnk.fetch),
      .cra_done(lnk.cra_done), .int_ack(lnk.int_ack),
      .rs_vld(lnk.rs_vld), .rt_int(lnk.rt_int), .int_addr(lnk.int_addr));
   always #20 i_clk = ~i_clk;
   // takes can land inside other tasks, so they are logged here
   always @(negedge i_clk) begin
      if (take === 1'h1) begin
         tk_cnt++;
         tk_addr = iaddr;
      end
      if (perr === 1'h1) begin
         pe_cnt++;
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [14:0] exp_addr(input logic [5:0] ln);
      return {base, ln, 2'h0};
   endfunction
   task automatic op(input rtir_cmd_t c, input logic [5:0] ln);
      @(posedge i_clk);
      cvld <= 1'h1;
      cmd <= c;
      cline <= ln;
      @(posedge i_clk);
      cvld <= 1'h0;
   endtask
   task automatic pulse(input int k);
      @(posedge i_clk);
      pl[k] <= 1'h1;
      @(posedge i_clk);
      pl[k] <= 1'h0;
   endtask
   task automatic wait_take(input logic [5:0] ln);
      int n;
      n = 0;
      while (tk_cnt == tk_done && n < 60) begin
         @(negedge i_clk);
         n++;
      end
      tk_done = tk_cnt;
      chk("int_addr", {17'h0, exp_addr(ln)}, {17'h0, tk_addr});
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge i_clk);
         chk("rt_int", 32'h0, {31'h0, lnk.rt_int});
      end
   endtask
   task automatic store();
      for (int k = 0; k < 4; k++) begin
         @(posedge i_clk);
         d[k] = 24'($urandom);
         sv <= 1'h1;
         sdata <= d[k];
      end
      @(posedge i_clk);
      sv <= 1'h0;
   endtask
   task automatic rest(input rtir_cmd_t c, input logic [5:0] ln);
      int n;
      n = 0;
      op(c, ln);
      repeat (8) begin
         @(negedge i_clk);
         if (rs_vld === 1'h1) begin
            if (n < 4) chk("rs_data", {8'h0, d[n]}, {8'h0, rs_data});
            n++;
         end
      end
      chk("rs_count", (ln < 6'h10) ? 4 : 0, n);
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      final_report();
   end
   initial begin
      irq = '0;
      fm = '0;
      cvld = 1'h0;
      cmd = `RTIR_CMD_NONE;
      cline = '0;
      pl = '0;
      se = 1'h0;
      sv = 1'h0;
      sdata = '0;
      bad_count = 0;
      n_tests = 0;
      tk_cnt = 0;
      tk_done = 0;
      pe_cnt = 0;
      void'($urandom(32'h72A5));
      base = 7'($urandom);
      repeat (5) @(posedge i_clk);
      i_srst <= 1'h0;
      op(`RTIR_CMD_BASE, 6'h00);
      op(`RTIR_CMD_ENABLE, 6'h00);
      // low lines: corners first, then a random one
      for (int i = 0; i < 3; i++) begin
         l = (i == 0) ? 6'h00 : (i == 1) ? 6'h0F : 6'($urandom_range(14, 1));
         @(posedge i_clk);
         irq[l] <= 1'h1;
         wait_take(l);
         chk("rt_flag", 32'h1, {31'h0, rt_flag});
         @(posedge i_clk);
         irq[l] <= 1'h0;
         store();
         pulse(1);
         rest((i == 2) ? `RTIR_CMD_RST_INT : `RTIR_CMD_RESTORE, l);
         pulse(1);
         @(negedge i_clk);
         chk("rt_disabled", 32'h1, {31'h0, rt_dis});
         pulse(0);
         @(negedge i_clk);
         chk("rt_disabled", 32'h0, {31'h0, rt_dis});
      end
      chk("restore_int", 32'h0, {31'h0, rst_int});
      @(posedge i_clk);
      se <= 1'h1;
      @(negedge i_clk);
      chk("restore_int", 32'h1, {31'h0, rst_int});
      pulse(3);
      @(negedge i_clk);
      chk("restore_int", 32'h0, {31'h0, rst_int});
      chk("rt_flag", 32'h0, {31'h0, rt_flag});
      // forced high line, then a higher line waits out the lock
      h = 6'($urandom_range(63, 40));
      g = 6'($urandom_range(39, 16));
      @(posedge i_clk);
      fm[h] <= 1'h1;
      op(`RTIR_CMD_FORCE, 6'h00);
      fm <= '0;
      wait_take(h);
      @(posedge i_clk);
      irq[h] <= 1'h1;
      irq[g] <= 1'h1;
      quiet(8);
      pulse(2);
      wait_take(g);
      @(posedge i_clk);
      irq[g] <= 1'h0;
      pulse(2);
      rest(`RTIR_CMD_RESTORE, g);
      pulse(0);
      wait_take(h);
      @(posedge i_clk);
      irq[h] <= 1'h0;
      pulse(2);
      rest(`RTIR_CMD_RESTORE, h);
      pulse(0);
      rest(`RTIR_CMD_RESTORE, 6'h3F);
      pulse(0);
      // disabled lines still record; program clear wipes them
      op(`RTIR_CMD_DISABLE, 6'h00);
      @(posedge i_clk);
      irq[g] <= 1'h1;
      quiet(6);
      chk("recorded", 32'h1, {31'h0, rec[g]});
      @(posedge i_clk);
      irq[g] <= 1'h0;
      repeat (4) @(posedge i_clk);
      op(`RTIR_CMD_CLEAR, 6'h00);
      @(negedge i_clk);
      chk("recorded", 32'h0, {31'h0, |rec});
      chk("enabled", 32'h0, {31'h0, en});
      chk("parity_err", 32'h0, pe_cnt);
      final_report();
   end
endmodule
